// ==== rtl/msc_config_bank.v ====
// Measurement configuration word and alarm limits with decoded front-end settings
`timescale 1ns/1ns
`include "msc_defs.vh"
module msc_config_bank
(
   input wire ref_clk,
   input wire rst,
   input wire cfg_wr,
   input wire [7:0] cfg_addr,
   input wire [15:0] cfg_wdata,
   output reg [15:0] cfg_rdata,
   output reg cfg_addr_hit,
   output reg [7:0] first_preamp_gain_value,
   output reg [7:0] second_preamp_gain_value,
   output reg chopper_invert,
   output reg [4:0] conversion_bits,
   output reg conversion_bits_valid,
   output reg absolute_voltage_input_select,
   output reg negative_input_to_analog_ground,
   output reg [2:0] offset_shift_code,
   output reg [15:0] offset_shift_pct_x100,
   output reg [1:0] converter_gain,
   output wire [23:0] alarm_limit_one,
   output wire [23:0] alarm_limit_two,
   output wire alarm_limit_one_pending,
   output wire alarm_limit_two_pending
);
   wire [15:0] setup_word;
   wire [15:0] lim1_lo_word;
   wire [15:0] lim2_lo_word;
   wire [15:0] lim_hi_word;
   wire wr_setup;
   wire wr_lim1;
   wire wr_lim2;
   wire wr_hi;
   wire [2:0] g1_code;
   wire [2:0] g2_code;
   wire [3:0] res_code;
   wire [2:0] ofs_code;
   wire shift_on;

   // Gain of the first stage as an integer
   function [7:0] first_gain;
      input [2:0] code;
      begin
         case (code)
            3'h0: first_gain = 8'h06;
            3'h1: first_gain = 8'h0C;
            3'h2: first_gain = 8'h14;
            3'h3: first_gain = 8'h1E;
            3'h4: first_gain = 8'h28;
            3'h5: first_gain = 8'h3C;
            3'h6: first_gain = 8'h50;
            default: first_gain = 8'h78;
         endcase
      end
   endfunction

   // Offset compensation in hundredths of a percent
   function [15:0] offset_pct;
      input [2:0] code;
      begin
         case (code)
            3'h0: offset_pct = 16'h0000;
            3'h1: offset_pct = 16'h02A3;
            3'h2: offset_pct = 16'h04E2;
            3'h3: offset_pct = 16'h0785;
            3'h4: offset_pct = 16'h09C4;
            3'h5: offset_pct = 16'h0C67;
            3'h6: offset_pct = 16'h0F0A;
            default: offset_pct = 16'h10E5;
         endcase
      end
   endfunction

   assign wr_setup = cfg_wr & (cfg_addr == `MSC_ADDR_SETUP);
   assign wr_lim1 = cfg_wr & (cfg_addr == `MSC_ADDR_LIM1_LO);
   assign wr_lim2 = cfg_wr & (cfg_addr == `MSC_ADDR_LIM2_LO);
   assign wr_hi = cfg_wr & (cfg_addr == `MSC_ADDR_LIM_HI);

   msc_word_reg #(.RESET_VALUE(`MSC_RST_SETUP)) u_setup
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_setup),
      .wr_data(cfg_wdata),
      .word_out(setup_word)
   );

   msc_word_reg #(.RESET_VALUE(`MSC_RST_LIMIT)) u_lim1_lo
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_lim1),
      .wr_data(cfg_wdata),
      .word_out(lim1_lo_word)
   );

   msc_word_reg #(.RESET_VALUE(`MSC_RST_LIMIT)) u_lim2_lo
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_lim2),
      .wr_data(cfg_wdata),
      .word_out(lim2_lo_word)
   );

   msc_word_reg #(.RESET_VALUE(`MSC_RST_LIMIT)) u_lim_hi
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_hi),
      .wr_data(cfg_wdata),
      .word_out(lim_hi_word)
   );

   // The shared upper word counts as a fresh part for both limits
   msc_limit_pair u_limit_one
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .low_wr(wr_lim1),
      .high_wr(wr_hi),
      .low_word(lim1_lo_word),
      .high_byte(lim_hi_word[7:0]),
      .limit_out(alarm_limit_one),
      .limit_pending(alarm_limit_one_pending)
   );

   msc_limit_pair u_limit_two
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .low_wr(wr_lim2),
      .high_wr(wr_hi),
      .low_word(lim2_lo_word),
      .high_byte(lim_hi_word[15:8]),
      .limit_out(alarm_limit_two),
      .limit_pending(alarm_limit_two_pending)
   );

   assign g1_code = setup_word[`MSC_G1_MSB:`MSC_G1_LSB];
   assign g2_code = setup_word[`MSC_G2_MSB:`MSC_G2_LSB];
   assign res_code = setup_word[`MSC_RES_MSB:`MSC_RES_LSB];
   assign ofs_code = setup_word[`MSC_OFS_MSB:`MSC_OFS_LSB];
   assign shift_on = setup_word[`MSC_SHIFT_BIT];

   // Read path is registered; unmapped addresses read zero with no hit
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_rdata <= 16'h0000;
         cfg_addr_hit <= 1'b0;
      end
      else
      begin
         cfg_addr_hit <= (cfg_addr >= `MSC_ADDR_SETUP) && (cfg_addr <= `MSC_ADDR_LIM_HI);
         case (cfg_addr)
            `MSC_ADDR_SETUP: cfg_rdata <= setup_word;
            `MSC_ADDR_LIM1_LO: cfg_rdata <= lim1_lo_word;
            `MSC_ADDR_LIM2_LO: cfg_rdata <= lim2_lo_word;
            `MSC_ADDR_LIM_HI: cfg_rdata <= lim_hi_word;
            default: cfg_rdata <= 16'h0000;
         endcase
      end
   end

   // Decoded settings, registered so the analog side sees clean levels
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         first_preamp_gain_value <= 8'h06;
         second_preamp_gain_value <= 8'h0B;
         chopper_invert <= 1'b0;
         conversion_bits <= `MSC_RES_BASE_BITS;
         conversion_bits_valid <= 1'b1;
         absolute_voltage_input_select <= 1'b0;
         negative_input_to_analog_ground <= 1'b0;
         offset_shift_code <= 3'h0;
         offset_shift_pct_x100 <= 16'h0000;
         converter_gain <= 2'h1;
      end
      else
      begin
         first_preamp_gain_value <= first_gain(g1_code);
         // Second gain in tenths: 11 + code
         second_preamp_gain_value <= 8'h0B + {5'h00, g2_code};
         chopper_invert <= setup_word[`MSC_POL_BIT];
         conversion_bits <= `MSC_RES_BASE_BITS + {1'b0, res_code};
         conversion_bits_valid <= (res_code <= `MSC_RES_MAX_CODE);
         absolute_voltage_input_select <= setup_word[`MSC_ABS_BIT];
         negative_input_to_analog_ground <= setup_word[`MSC_ABS_BIT];
         // Gated by the method bit so a stale field never shifts the converter
         offset_shift_code <= shift_on ? ofs_code : 3'h0;
         offset_shift_pct_x100 <= shift_on ? offset_pct(ofs_code) : 16'h0000;
         converter_gain <= shift_on ? 2'h2 : 2'h1;
      end
   end
endmodule

// ==== rtl/msc_defs.vh ====
// Constants for the measurement configuration and alarm limit bank
// Function
// - First preamp code bits 2:0 select 6..120
// - Second preamp code bits 5:3 select 1.1..1.8
// - Bit 6 set inverts the chopper polarity
// - Bits 10:7 pick 12 to 18 bit resolution
// - Bit 11 selects absolute-voltage input mode
// - Bits 14:12 select offset compensation percentage
// - Offset shift applies only with bit 15 set
// - Bit 15 selects converter gain one or two
// - Limit one is 0x15[7:0] over 0x13
// - Limit two is 0x15[15:8] over 0x14
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH
`define MSC_ADDR_SETUP 8'h12
`define MSC_ADDR_LIM1_LO 8'h13
`define MSC_ADDR_LIM2_LO 8'h14
`define MSC_ADDR_LIM_HI 8'h15
`define MSC_RST_SETUP 16'h0000
`define MSC_RST_LIMIT 16'h0000
`define MSC_G1_LSB 0
`define MSC_G1_MSB 2
`define MSC_G2_LSB 3
`define MSC_G2_MSB 5
`define MSC_POL_BIT 6
`define MSC_RES_LSB 7
`define MSC_RES_MSB 10
`define MSC_ABS_BIT 11
`define MSC_OFS_LSB 12
`define MSC_OFS_MSB 14
`define MSC_SHIFT_BIT 15
`define MSC_RES_MAX_CODE 4'h6
`define MSC_RES_BASE_BITS 5'h0C
`endif

// ==== rtl/msc_limit_pair.v ====
// Assembles one 24-bit alarm limit and publishes it when both parts are fresh
`timescale 1ns/1ns
module msc_limit_pair
(
   input wire ref_clk,
   input wire rst,
   input wire low_wr,
   input wire high_wr,
   input wire [15:0] low_word,
   input wire [7:0] high_byte,
   output reg [23:0] limit_out,
   output wire limit_pending
);
   reg low_seen_reg;
   reg high_seen_reg;
   reg low_seen_next;
   reg high_seen_next;
   reg publish;

   // Writes land in the word registers this cycle; the stored words are
   // visible one cycle later, so publication is delayed by one edge.
   reg publish_d_reg;

   always @*
   begin
      low_seen_next = low_seen_reg | low_wr;
      high_seen_next = high_seen_reg | high_wr;
      publish = low_seen_next & high_seen_next;
      if (publish)
      begin
         low_seen_next = 1'b0;
         high_seen_next = 1'b0;
      end
   end

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         low_seen_reg <= 1'b0;
         high_seen_reg <= 1'b0;
         publish_d_reg <= 1'b0;
         limit_out <= 24'h00_0000;
      end
      else
      begin
         low_seen_reg <= low_seen_next;
         high_seen_reg <= high_seen_next;
         publish_d_reg <= publish;
         if (publish_d_reg)
         begin
            limit_out <= {high_byte, low_word};
         end
      end
   end

   assign limit_pending = low_seen_reg | high_seen_reg | publish_d_reg;
endmodule

// ==== rtl/msc_word_reg.v ====
// One 16-bit configuration word with write strobe and registered value
`timescale 1ns/1ns
module msc_word_reg
#(
   parameter [15:0] RESET_VALUE = 16'h0000
)
(
   input wire ref_clk,
   input wire rst,
   input wire wr_en,
   input wire [15:0] wr_data,
   output wire [15:0] word_out
);
   reg [15:0] word_reg;

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         word_reg <= RESET_VALUE;
      end
      else if (wr_en)
      begin
         word_reg <= wr_data;
      end
   end

   assign word_out = word_reg;
endmodule

// ==== verification/msc_config_bank_sva.sv ====
// Checker for decoded settings and alarm limit publishing
`timescale 1ns/1ns
module msc_config_bank_chk
(
   input wire ref_clk,
   input wire rst,
   input wire cfg_wr,
   input wire [7:0] cfg_addr,
   input wire [15:0] cfg_wdata,
   input wire [7:0] first_preamp_gain_value,
   input wire [7:0] second_preamp_gain_value,
   input wire chopper_invert,
   input wire [4:0] conversion_bits,
   input wire conversion_bits_valid,
   input wire absolute_voltage_input_select,
   input wire negative_input_to_analog_ground,
   input wire [2:0] offset_shift_code,
   input wire [1:0] converter_gain,
   input wire [23:0] alarm_limit_one,
   input wire [23:0] alarm_limit_two,
   input wire alarm_limit_one_pending,
   input wire alarm_limit_two_pending
);
   localparam [63:0] G1 = 64'h7850_3C28_1E14_0C06;
   wire setup_wr = cfg_wr && cfg_addr == 8'h12;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   chk_gain1_map: assert property (setup_wr |-> ##2
      first_preamp_gain_value == G1[8 * $past(cfg_wdata[2:0], 2) +: 8]) else $error("gain1");
   chk_gain2_map: assert property (setup_wr |-> ##2
      second_preamp_gain_value == 8'h0B + $past(cfg_wdata[5:3], 2)) else $error("gain2");
   chk_chop_pol: assert property (setup_wr |-> ##2
      chopper_invert == $past(cfg_wdata[6], 2)) else $error("polarity");
   chk_res_bits: assert property (setup_wr |-> ##2
      conversion_bits == 5'h0C + $past(cfg_wdata[10:7], 2)) else $error("bits");
   chk_res_valid: assert property (setup_wr |-> ##2
      conversion_bits_valid == ($past(cfg_wdata[10:7], 2) <= 4'h6)) else $error("valid");
   chk_abs_input: assert property (setup_wr |-> ##2
      absolute_voltage_input_select == $past(cfg_wdata[11], 2)
      && negative_input_to_analog_ground == $past(cfg_wdata[11], 2)) else $error("abs");
   chk_shift_code: assert property (setup_wr |-> ##2
      offset_shift_code == ($past(cfg_wdata[15], 2) ? $past(cfg_wdata[14:12], 2) : 3'h0))
      else $error("shift");
   chk_conv_gain: assert property (setup_wr |-> ##2
      converter_gain == ($past(cfg_wdata[15], 2) ? 2'h2 : 2'h1)) else $error("conv gain");
   chk_lim1_hold: assert property ($changed(alarm_limit_one) |->
      $past(alarm_limit_one_pending)) else $error("limit one");
   chk_lim2_hold: assert property ($changed(alarm_limit_two) |->
      $past(alarm_limit_two_pending)) else $error("limit two");
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the configuration bank
`timescale 1ns/1ns
module testbench;
   logic ref_clk, rst, cfg_wr, cfg_addr_hit, chopper_invert, conversion_bits_valid;
   logic absolute_voltage_input_select, negative_input_to_analog_ground;
   logic alarm_limit_one_pending, alarm_limit_two_pending;
   logic [7:0] cfg_addr, first_preamp_gain_value, second_preamp_gain_value;
   logic [15:0] cfg_wdata, cfg_rdata, offset_shift_pct_x100, w, r;
   logic [4:0] conversion_bits;
   logic [2:0] offset_shift_code;
   logic [1:0] converter_gain;
   logic [23:0] alarm_limit_one, alarm_limit_two, lim1, lim2;
   logic [15:0] mdl [0:3];
   logic [3:0] f;
   int g1t [0:7] = '{6, 12, 20, 30, 40, 60, 80, 120};
   int pct [0:7] = '{0, 675, 1250, 1925, 2500, 3175, 3850, 4325};
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   msc_config_bank u_dut (.*);
   initial
   begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   task give_verdict;
      $display("mismatches %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         give_verdict;
      end
   end
   task cmp(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task do_rst;
      rst = 1;
      mdl = '{default: 16'h0000};
      f = 0;
      lim1 = 0;
      lim2 = 0;
      repeat (20) @(negedge ref_clk);
      rst = 0;
   endtask
   // Holds the strobe high so back-to-back writes need no gap
   task wr(input logic [7:0] a, input logic [15:0] d);
      cfg_wr = 1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge ref_clk);
      if (a >= 8'h12 && a <= 8'h15)
         mdl[a - 8'h12] = d;
      f = f | (a == 8'h13 ? 4'h1 : a == 8'h14 ? 4'h2 : a == 8'h15 ? 4'hC : 4'h0);
      if (f[0] && f[2])
      begin
         lim1 = {mdl[3][7:0], mdl[1]};
         f = f & 4'hA;
      end
      if (f[1] && f[3])
      begin
         lim2 = {mdl[3][15:8], mdl[2]};
         f = f & 4'h5;
      end
   endtask
   task idle(input int n);
      cfg_wr = 0;
      repeat (n) @(negedge ref_clk);
   endtask
   task rd(input logic [7:0] a);
      cfg_wr = 0;
      cfg_addr = a;
      @(negedge ref_clk);
      cmp(cfg_rdata, (a >= 8'h12 && a <= 8'h15) ? mdl[a - 8'h12] : 16'h0000);
      cmp(cfg_addr_hit, a >= 8'h12 && a <= 8'h15);
   endtask
   task chk_dec;
      w = mdl[0];
      cmp(first_preamp_gain_value, g1t[w[2:0]]);
      cmp(second_preamp_gain_value, 11 + w[5:3]);
      cmp(chopper_invert, w[6]);
      cmp(conversion_bits, 12 + w[10:7]);
      cmp(conversion_bits_valid, w[10:7] <= 6);
      cmp({absolute_voltage_input_select, negative_input_to_analog_ground}, {2{w[11]}});
      cmp(offset_shift_code, w[15] ? w[14:12] : 3'h0);
      cmp(offset_shift_pct_x100, w[15] ? pct[w[14:12]] : 0);
      cmp(converter_gain, w[15] ? 2 : 1);
      cmp(alarm_limit_one, lim1);
      cmp(alarm_limit_two, lim2);
      cmp({alarm_limit_one_pending, alarm_limit_two_pending}, {f[0] | f[2], f[1] | f[3]});
   endtask
   initial
   begin
      cfg_wr = 0;
      cfg_addr = 0;
      cfg_wdata = 0;
      void'($urandom(17));
      do_rst;
      chk_dec;
      for (int a = 8'h11; a <= 8'h16; a++) rd(a);
      for (int i = 0; i < 16; i++)
      begin
         r = 16'($urandom);
         // Offset field kept zero whenever the shift method is off; odd passes
         // step through every compensation code so each table entry is seen
         w = {i[0], i[0] ? i[3:1] : 3'h0, r[11], i[3:0], r[6:3], i[2:0]};
         wr(8'h12, w);
         idle(1);
         chk_dec;
         rd(8'h12);
      end
      wr(8'h13, 16'h1234);
      idle(3);
      chk_dec;
      wr(8'h15, 16'($urandom));
      idle(3);
      chk_dec;
      wr(8'h14, 16'($urandom));
      idle(3);
      chk_dec;
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h13, 16'($urandom));
         wr(8'h14, 16'($urandom));
         wr(8'h15, 16'($urandom));
         idle(3);
         chk_dec;
         rd(8'h15);
      end
      wr(8'h16, 16'hFFFF);
      wr(8'h11, 16'hFFFF);
      wr(8'h14, 16'h5A5A);
      idle(3);
      chk_dec;
      rd(8'h16);
      rd(8'h14);
      do_rst;
      chk_dec;
      for (int a = 8'h12; a <= 8'h15; a++) rd(a);
      give_verdict;
   end
endmodule
bind msc_config_bank msc_config_bank_chk u_chk (.*);
